// *** pci_cmd_align.sv ***
// Top: master command selection, effective line size and burst alignment stepping.
`timescale 1ns/1ps
// Summary of operation
// - Command code travels on command/byte-enable lines in the address phase.
// - I/O read and write compare address bits 31:8 against the I/O base.
// - All memory read and write commands decode address bits 31:8 only.
// - Master issues only I/O and memory commands, never special or config cycles.
// - Target answers I/O, memory and configuration; ignores the rest.
// - Incoming read multiple or read line acts as plain memory read.
// - Incoming write-and-invalidate acts as plain memory write.
// - Read line is issued only with the read-line enable set.
// - Read multiple is issued only with the read-multiple enable set.
// - Write-and-invalidate needs the write-invalidate enable set.
// - An 8-bit cache line size input detects misaligned addresses.
// - Each of the three cache commands is enabled on its own.
// - Line size rounds down to a power of two from 2 to 128.
// - With cache mode on and a usable line size, effective line is the smaller of rounded line and burst size; else burst size.
// - Effective line limits every master burst.
// - Misaligned addresses step toward the line boundary without crossing.
// - Below a 4-dword boundary single-dword transfers are used.
// - Then the largest aligned burst not above the line is chosen.
// - Alignment is re-evaluated after every burst.
// - Stepping ends at a line boundary or when data runs out.
// - Past a line boundary bursts use the effective line size.
// - Write-and-invalidate also needs the command register enable bit.
// - Cache mode off disables alignment; read line then used whenever its enable is set.
module pci_cmd_align (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Configuration
  input  wire logic [7:0]  cache_line_size_i,
  input  wire logic [7:0]  dma_mode_reg_i,
  input  wire logic [7:0]  chip_test_three_reg_i,
  input  wire logic [7:0]  chip_test_five_reg_i,
  input  wire logic [7:0]  pci_command_reg_i,
  input  wire logic        cache_mode_enable_i,
  // Transfer job
  input  wire logic        start_i,
  input  wire logic [31:0] start_addr_i,
  input  wire logic [23:0] byte_count_i,
  input  wire logic        job_write_i,
  input  wire logic        job_io_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [8:0]       eff_line_o,
  // Master request stream
  output logic             req_valid_o,
  input  wire logic        req_ready_i,
  output logic [31:0]      req_addr_o,
  output logic [3:0]       req_cmd_o,
  output logic [8:0]       req_dwords_o,
  output logic [3:0]       req_be_n_o,
  // Target address phase
  input  wire logic        addr_phase_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_i,
  input  wire logic        idsel_i,
  input  wire logic [23:0] io_base_i,
  input  wire logic [23:0] mem_base_i,
  output logic             tgt_hit_o,
  output logic [3:0]       tgt_cmd_o,
  output logic [7:0]       tgt_reg_o
);
  // ----------------------------------------------------------------
  // Effective line size
  // ----------------------------------------------------------------
  logic [8:0] cls_round, burst_sz, eff_d, eff_q;
  logic       cls_ok_d, cls_ok_q, cache_on;
  logic [2:0] burst_code;

  // The highest set bit wins, so any programmed size rounds down to a power of two.
  // Sizes 0 and 1 leave the result zero, which marks the line size as unusable.
  always_comb begin
    cls_round = 9'h000;
    for (int k = 1; k < 8; k++) begin
      if (cache_line_size_i[k]) begin
        cls_round = 9'(1 << k);
      end
    end
  end

  assign burst_code = {chip_test_five_reg_i[pci_cmd_pkg::BURST_HI_BIT],
                       dma_mode_reg_i[pci_cmd_pkg::BURST_MSB:pci_cmd_pkg::BURST_LSB]};

  // Code seven would ask for 256 dwords; it is held at the largest supported burst.
  always_comb begin
    burst_sz = pci_cmd_pkg::MIN_BURST << burst_code;
    if (burst_sz > pci_cmd_pkg::MAX_LINE) begin
      burst_sz = pci_cmd_pkg::MAX_LINE;
    end
    cls_ok_d = (cls_round != 9'h000);
    if (cache_mode_enable_i && cls_ok_d) begin
      eff_d = (cls_round < burst_sz) ? cls_round : burst_sz;
    end else begin
      eff_d = burst_sz;
    end
  end

  // Validity is registered so that the alignment choice stays in step with eff_q.
  assign cache_on = cache_mode_enable_i && cls_ok_q;

  // ----------------------------------------------------------------
  // Burst size and command choice
  // ----------------------------------------------------------------
  // Sizes are counted in dwords, while the remaining count is in bytes.
  function automatic logic [8:0] pick_size(input logic [31:0] a, input logic [23:0] r,
                                           input logic [8:0] line, input logic align);
    logic [31:0] bytes;
    logic [8:0]  p;
    p = pci_cmd_pkg::SINGLE_DW;
    if (!align) begin
      bytes = 32'(line) << 2;
      if (a[1:0] == 2'h0 && 32'(r) >= bytes) begin
        p = line;
      end
    end else if (a[3:0] == 4'h0 && 32'(r) >= 32'h10) begin
      // A two-dword line is below the stepping threshold, so it caps the step.
      p = (line < pci_cmd_pkg::STEP_DW) ? line : pci_cmd_pkg::STEP_DW;
      for (int k = 3; k < 8; k++) begin
        bytes = 32'h1 << (k + 2);
        if ((9'(1 << k) <= line) && ((a & (bytes - 32'h1)) == 32'h0) &&
            (32'(r) >= bytes)) begin
          p = 9'(1 << k);
        end
      end
    end
    return p;
  endfunction

  logic [31:0] addr_q, addr_d, line_mask;
  logic [23:0] rem_q, rem_d;
  logic        wr_q, wr_d, io_q, io_d;
  logic [8:0]  size_now;
  logic [3:0]  cmd_now, be_mask;
  logic [2:0]  n_bytes;
  logic        line_al;

  // Line alignment is judged against the registered effective size.
  assign line_mask = (32'(eff_q) << 2) - 32'h1;
  assign line_al   = ((addr_q & line_mask) == 32'h0);

  always_comb begin
    if (io_q) begin
      size_now = pci_cmd_pkg::SINGLE_DW;
    end else begin
      size_now = pick_size(addr_q, rem_q, eff_q, cache_on);
    end
  end

  // A single transfer may start mid-dword and may end early when few bytes remain.
  always_comb begin
    n_bytes = 3'(3'h4 - {1'b0, addr_q[1:0]});
    if (rem_q < 24'(n_bytes)) begin
      n_bytes = rem_q[2:0];
    end
    be_mask = 4'h0;
    for (int b = 0; b < 4; b++) begin
      if (b >= int'(addr_q[1:0]) && b < int'(addr_q[1:0]) + int'(n_bytes)) begin
        be_mask[b] = 1'b1;
      end
    end
  end

  // With cache mode on, the cache commands are offered only at a line boundary.
  always_comb begin
    if (io_q) begin
      cmd_now = wr_q ? pci_cmd_pkg::CMD_IO_WR : pci_cmd_pkg::CMD_IO_RD;
    end else if (wr_q) begin
      cmd_now = pci_cmd_pkg::CMD_MEM_WR;
      if (cache_on && line_al && size_now == eff_q && eff_q <= burst_sz &&
          chip_test_three_reg_i[pci_cmd_pkg::WR_INV_EN_BIT] &&
          pci_command_reg_i[pci_cmd_pkg::MWI_CMD_BIT]) begin
        cmd_now = pci_cmd_pkg::CMD_WR_INV;
      end
    end else begin
      cmd_now = pci_cmd_pkg::CMD_MEM_RD;
      if (!cache_on) begin
        if (dma_mode_reg_i[pci_cmd_pkg::RD_LINE_EN_BIT]) begin
          cmd_now = pci_cmd_pkg::CMD_RD_LINE;
        end
      end else if (line_al && eff_q <= burst_sz) begin
        if (dma_mode_reg_i[pci_cmd_pkg::RD_MULT_EN_BIT] &&
            32'(rem_q) >= (32'(eff_q) << 3)) begin
          cmd_now = pci_cmd_pkg::CMD_RD_MULT;
        end else if (dma_mode_reg_i[pci_cmd_pkg::RD_LINE_EN_BIT] &&
                     32'(rem_q) >= (32'(burst_sz) << 2)) begin
          cmd_now = pci_cmd_pkg::CMD_RD_LINE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Stepping engine
  // ----------------------------------------------------------------
  pci_cmd_pkg::eng_state_t st_q, st_d;
  logic done_q, done_d;
  burst_req_if req_if ();

  // The request is offered every cycle in RUN while bytes remain; the address moves only when it is taken.
  always_comb begin
    st_d         = st_q;
    addr_d       = addr_q;
    rem_d        = rem_q;
    wr_d         = wr_q;
    io_d         = io_q;
    done_d       = 1'b0;
    req_if.valid = 1'b0;
    req_if.data  = {addr_q, cmd_now, size_now,
                    (size_now == pci_cmd_pkg::SINGLE_DW) ? ~be_mask : 4'h0};
    case (st_q)
      pci_cmd_pkg::ST_IDLE: begin
        if (start_i) begin
          addr_d = start_addr_i;
          rem_d  = byte_count_i;
          wr_d   = job_write_i;
          io_d   = job_io_i;
          st_d   = pci_cmd_pkg::ST_RUN;
        end
      end
      pci_cmd_pkg::ST_RUN: begin
        if (rem_q == pci_cmd_pkg::CNT_RST) begin
          st_d   = pci_cmd_pkg::ST_IDLE;
          done_d = 1'b1;
        end else begin
          req_if.valid = 1'b1;
          if (req_if.ready) begin
            if (size_now == pci_cmd_pkg::SINGLE_DW) begin
              addr_d = {addr_q[31:2], 2'b00} + 32'h4;
              rem_d  = rem_q - 24'(n_bytes);
            end else begin
              addr_d = addr_q + (32'(size_now) << 2);
              rem_d  = rem_q - 24'(32'(size_now) << 2);
            end
          end
        end
      end
      default: st_d = pci_cmd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q     <= pci_cmd_pkg::ST_IDLE;
      addr_q   <= pci_cmd_pkg::ADDR_RST;
      rem_q    <= pci_cmd_pkg::CNT_RST;
      wr_q     <= 1'b0;
      io_q     <= 1'b0;
      done_q   <= 1'b0;
      eff_q    <= pci_cmd_pkg::LINE_RST;
      cls_ok_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      addr_q   <= addr_d;
      rem_q    <= rem_d;
      wr_q     <= wr_d;
      io_q     <= io_d;
      done_q   <= done_d;
      eff_q    <= eff_d;
      cls_ok_q <= cls_ok_d;
    end
  end

  assign busy_o     = (st_q == pci_cmd_pkg::ST_RUN);
  assign done_o     = done_q;
  assign eff_line_o = eff_q;

  // ----------------------------------------------------------------
  // Output buffer and target decode
  // ----------------------------------------------------------------
  logic [pci_cmd_pkg::REQ_W-1:0] out_data;

  // The buffer decouples the engine from a stalling receiver and registers the outputs.
  req_skid_buf #(.WIDTH(pci_cmd_pkg::REQ_W)) u_buf (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_if       (req_if),
    .out_valid_o (req_valid_o),
    .out_ready_i (req_ready_i),
    .out_data_o  (out_data)
  );

  assign {req_addr_o, req_cmd_o, req_dwords_o, req_be_n_o} = out_data;

  // Target decode runs on its own, independent of the master engine.
  target_cmd_decode u_tgt (
    .clock_i      (clock_i),
    .rstn_i       (rstn_i),
    .addr_phase_i (addr_phase_i),
    .ad_i         (ad_i),
    .cbe_i        (cbe_i),
    .idsel_i      (idsel_i),
    .io_base_i    (io_base_i),
    .mem_base_i   (mem_base_i),
    .hit_o        (tgt_hit_o),
    .hit_cmd_o    (tgt_cmd_o),
    .hit_reg_o    (tgt_reg_o)
  );
endmodule

// *** pci_cmd_pkg.sv ***
// Shared constants for PCI command handling and cache-line burst alignment.
package pci_cmd_pkg;
  // ----------------------------------------------------------------
  // Bus command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_INT_ACK  = 4'h0;
  localparam logic [3:0] CMD_SPECIAL  = 4'h1;
  localparam logic [3:0] CMD_IO_RD    = 4'h2;
  localparam logic [3:0] CMD_IO_WR    = 4'h3;
  localparam logic [3:0] CMD_MEM_RD   = 4'h6;
  localparam logic [3:0] CMD_MEM_WR   = 4'h7;
  localparam logic [3:0] CMD_CFG_RD   = 4'ha;
  localparam logic [3:0] CMD_CFG_WR   = 4'hb;
  localparam logic [3:0] CMD_RD_MULT  = 4'hc;
  localparam logic [3:0] CMD_DUAL     = 4'hd;
  localparam logic [3:0] CMD_RD_LINE  = 4'he;
  localparam logic [3:0] CMD_WR_INV   = 4'hf;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RD_LINE_EN_BIT = 3;
  localparam int RD_MULT_EN_BIT = 2;
  localparam int WR_INV_EN_BIT  = 0;
  localparam int BURST_HI_BIT   = 2;
  localparam int MWI_CMD_BIT    = 4;
  localparam int BURST_LSB      = 6;
  localparam int BURST_MSB      = 7;
  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int SIZE_W         = 9;
  localparam int CNT_W          = 24;
  localparam logic [8:0] MAX_LINE   = 9'h080;
  localparam logic [8:0] STEP_DW    = 9'h004;
  localparam logic [8:0] SINGLE_DW  = 9'h001;
  localparam logic [8:0] MIN_BURST  = 9'h002;
  localparam int REQ_W          = 32 + 4 + SIZE_W + 4;
  localparam logic [8:0] LINE_RST   = 9'h002;
  localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [23:0] CNT_RST   = 24'h00_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } eng_state_t;
endpackage

// *** burst_req_if.sv ***
// Burst request carrier between the alignment engine and the output buffer.
`timescale 1ns/1ps
interface burst_req_if;
  logic                         valid;
  logic                         ready;
  logic [pci_cmd_pkg::REQ_W-1:0] data;
  modport src (output valid, output data, input  ready);
  modport snk (input  valid, input  data, output ready);
endinterface

// *** req_skid_buf.sv ***
// Two-entry request buffer; both outputs come from flops and a stall loses nothing.
`timescale 1ns/1ps
module req_skid_buf #(
  parameter int WIDTH = pci_cmd_pkg::REQ_W
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Filling side
  burst_req_if.snk              in_if,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  logic             out_v_q, out_v_d, spare_v_q, spare_v_d;
  logic [WIDTH-1:0] out_q, out_d, spare_q, spare_d;

  // The spare entry absorbs the word in flight when the drain stalls.
  assign in_if.ready = !spare_v_q;

  always_comb begin
    out_v_d   = out_v_q;
    out_d     = out_q;
    spare_v_d = spare_v_q;
    spare_d   = spare_q;
    if (out_ready_i || !out_v_q) begin
      if (spare_v_q) begin
        out_d     = spare_q;
        out_v_d   = 1'b1;
        spare_v_d = 1'b0;
      end else begin
        out_d   = in_if.data;
        out_v_d = in_if.valid;
      end
    end else if (in_if.valid && !spare_v_q) begin
      spare_d   = in_if.data;
      spare_v_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_v_q   <= 1'b0;
      spare_v_q <= 1'b0;
      out_q     <= '0;
      spare_q   <= '0;
    end else begin
      out_v_q   <= out_v_d;
      spare_v_q <= spare_v_d;
      out_q     <= out_d;
      spare_q   <= spare_d;
    end
  end

  assign out_valid_o = out_v_q;
  assign out_data_o  = out_q;
endmodule

// *** target_cmd_decode.sv ***
// Target-side address-phase decode of bus commands and address match.
`timescale 1ns/1ps
module target_cmd_decode (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Address phase
  input  wire logic        addr_phase_i,
  input  wire logic [31:0] ad_i,
  input  wire logic [3:0]  cbe_i,
  input  wire logic        idsel_i,
  // Assigned bases, upper 24 bits
  input  wire logic [23:0] io_base_i,
  input  wire logic [23:0] mem_base_i,
  // Decode result
  output logic             hit_o,
  output logic [3:0]       hit_cmd_o,
  output logic [7:0]       hit_reg_o
);
  logic       hit_q, hit_d;
  logic [3:0] cmd_q, cmd_d;
  logic [7:0] reg_q, reg_d;

  always_comb begin
    hit_d = 1'b0;
    cmd_d = cmd_q;
    reg_d = reg_q;
    if (addr_phase_i) begin
      reg_d = ad_i[7:0];
      case (cbe_i)
        pci_cmd_pkg::CMD_IO_RD, pci_cmd_pkg::CMD_IO_WR: begin
          hit_d = (ad_i[31:8] == io_base_i);
          cmd_d = cbe_i;
        end
        pci_cmd_pkg::CMD_MEM_RD, pci_cmd_pkg::CMD_RD_MULT,
        pci_cmd_pkg::CMD_RD_LINE: begin
          hit_d = (ad_i[31:8] == mem_base_i);
          cmd_d = pci_cmd_pkg::CMD_MEM_RD;
        end
        pci_cmd_pkg::CMD_MEM_WR, pci_cmd_pkg::CMD_WR_INV: begin
          hit_d = (ad_i[31:8] == mem_base_i);
          cmd_d = pci_cmd_pkg::CMD_MEM_WR;
        end
        pci_cmd_pkg::CMD_CFG_RD, pci_cmd_pkg::CMD_CFG_WR: begin
          hit_d = idsel_i && (ad_i[10:8] == 3'h0);
          cmd_d = cbe_i;
        end
        default: hit_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hit_q <= 1'b0;
      cmd_q <= 4'h0;
      reg_q <= 8'h00;
    end else begin
      hit_q <= hit_d;
      cmd_q <= cmd_d;
      reg_q <= reg_d;
    end
  end

  assign hit_o     = hit_q;
  assign hit_cmd_o = cmd_q;
  assign hit_reg_o = reg_q;
endmodule

// *** pci_cmd_align_assertions.sv ***
// Port-level concurrent checks for the command and alignment block.
`timescale 1ns/1ps
module pci_cmd_align_assertions (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rstn_i,
  // Configuration and job
  input wire logic [7:0]  dma_mode_reg_i,
  input wire logic [7:0]  chip_test_three_reg_i,
  input wire logic [7:0]  pci_command_reg_i,
  input wire logic        cache_mode_enable_i,
  input wire logic        start_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [8:0]  eff_line_o,
  // Master stream
  input wire logic        req_valid_o,
  input wire logic        req_ready_i,
  input wire logic [31:0] req_addr_o,
  input wire logic [3:0]  req_cmd_o,
  input wire logic [8:0]  req_dwords_o,
  // Target decode
  input wire logic        addr_phase_i,
  input wire logic [3:0]  cbe_i,
  input wire logic        tgt_hit_o,
  input wire logic [3:0]  tgt_cmd_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_hit_cause; tgt_hit_o |-> $past(addr_phase_i); endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("target hit without address phase");
  property p_ignored; addr_phase_i && (cbe_i inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd}) |=> !tgt_hit_o; endproperty
  a_ignored: assert property (p_ignored) else $error("ignored command claimed");
  property p_rd_norm; addr_phase_i && (cbe_i inside {4'hc, 4'he}) ##1 tgt_hit_o |-> tgt_cmd_o == 4'h6; endproperty
  a_rd_norm: assert property (p_rd_norm) else $error("read variant not seen as plain read");
  property p_wr_norm; addr_phase_i && cbe_i == 4'hf ##1 tgt_hit_o |-> tgt_cmd_o == 4'h7; endproperty
  a_wr_norm: assert property (p_wr_norm) else $error("invalidating write not seen as plain write");
  property p_master_cmd; req_valid_o |-> req_cmd_o inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf}; endproperty
  a_master_cmd: assert property (p_master_cmd) else $error("master issued a forbidden command");
  property p_rd_line; req_valid_o && req_cmd_o == 4'he |-> dma_mode_reg_i[3]; endproperty
  a_rd_line: assert property (p_rd_line) else $error("read line while disabled");
  property p_rd_mult; req_valid_o && req_cmd_o == 4'hc |-> dma_mode_reg_i[2] && cache_mode_enable_i; endproperty
  a_rd_mult: assert property (p_rd_mult) else $error("read multiple while disabled");
  property p_wr_inv;
    req_valid_o && req_cmd_o == 4'hf |-> chip_test_three_reg_i[0] && pci_command_reg_i[4] && cache_mode_enable_i;
  endproperty
  a_wr_inv: assert property (p_wr_inv) else $error("invalidating write while disabled");
  property p_hold;
    req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_addr_o) && $stable(req_dwords_o) && $stable(req_cmd_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed while stalled");
  property p_limit; req_valid_o |-> req_dwords_o != 9'h000 && req_dwords_o <= eff_line_o; endproperty
  a_limit: assert property (p_limit) else $error("burst above effective line");
  property p_align;
    cache_mode_enable_i && req_valid_o && req_dwords_o > 9'h001 |-> (req_addr_o & ((32'(req_dwords_o) << 2) - 32'h1)) == 32'h0;
  endproperty
  a_align: assert property (p_align) else $error("burst not aligned to its size");
  property p_start; start_i && !busy_o |=> busy_o; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_end; $fell(busy_o) |-> done_o; endproperty
  a_end: assert property (p_end) else $error("job ended without done");
  c_wr_inv: cover property (req_valid_o && req_ready_i && req_cmd_o == 4'hf);
  c_rd_mult: cover property (req_valid_o && req_ready_i && req_cmd_o == 4'hc);
  c_hit: cover property (tgt_hit_o);
endmodule

// *** req_sink.sv ***
// Far-side consumer of master requests; it may stall at random.
`timescale 1ns/1ps
module req_sink (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Stream
  input  wire logic stall_i,
  output logic      req_ready_o
);
  logic [15:0] lfsr_q;
  logic [15:0] lfsr_d;
  always_comb begin
    lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lfsr_q <= 16'hace1;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end
  // A real target may hold off acceptance for any number of cycles.
  assign req_ready_o = !stall_i || lfsr_q[0];
endmodule

// *** test_pci_cmd_align.sv ***
// Self-checking bench for command choice, alignment stepping and target decode.
`timescale 1ns/1ps
module test_pci_cmd_align;
  logic        clock_i, rstn_i, start_i, job_write_i, job_io_i, cache_mode_enable_i, busy_o, done_o;
  logic        req_valid_o, req_ready_i, addr_phase_i, idsel_i, tgt_hit_o, stall, done_seen;
  logic [3:0]  req_cmd_o, req_be_n_o, cbe_i, tgt_cmd_o, m_cmd, m_be;
  logic [7:0]  cache_line_size_i, dma_mode_reg_i, chip_test_three_reg_i, chip_test_five_reg_i;
  logic [7:0]  pci_command_reg_i, tgt_reg_o;
  logic [8:0]  eff_line_o, req_dwords_o;
  logic [23:0] byte_count_i, io_base_i, mem_base_i;
  logic [31:0] start_addr_i, req_addr_o, ad_i, m_addr, seed, r;
  int          err_count, cmp_count, cycles, m_rem, m_eff, m_burst, m_k, m_n, m_line, i, j;

  pci_cmd_align u_dut (.*);
  req_sink u_sink (.clock_i(clock_i), .rstn_i(rstn_i), .stall_i(stall), .req_ready_o(req_ready_i));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ----------------------------------------------------------------
  // Reference model of the request stream
  // ----------------------------------------------------------------
  // Sampled at the falling edge, where registered outputs have settled.
  always @(negedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
    if (done_o === 1'b1) done_seen = 1'b1;
    if (rstn_i && req_valid_o === 1'b1 && req_ready_i) begin
      m_k = 1;
      m_line = (m_addr & (4 * m_eff - 1)) == 0;
      if (!job_io_i && cache_mode_enable_i) begin
        if (m_addr[3:0] == 4'h0 && m_rem >= 16 && m_eff < 4) m_k = m_eff;
        for (int k = 4; k <= m_eff; k = k * 2) begin
          if (m_addr[3:0] == 4'h0 && (m_addr & (4 * k - 1)) == 0 && m_rem >= 4 * k) m_k = k;
        end
      end else if (!job_io_i && m_addr[1:0] == 2'h0 && m_rem >= 4 * m_eff) begin
        m_k = m_eff;
      end
      if (job_io_i) m_cmd = job_write_i ? 4'h3 : 4'h2;
      else if (job_write_i) m_cmd = (cache_mode_enable_i && m_line && m_k == m_eff
                                     && chip_test_three_reg_i[0] && pci_command_reg_i[4]) ? 4'hf : 4'h7;
      else if (!cache_mode_enable_i) m_cmd = dma_mode_reg_i[3] ? 4'he : 4'h6;
      else if (m_line && dma_mode_reg_i[2] && m_rem >= 8 * m_eff) m_cmd = 4'hc;
      else if (m_line && dma_mode_reg_i[3] && m_rem >= 4 * m_burst) m_cmd = 4'he;
      else m_cmd = 4'h6;
      m_n = (m_k > 1) ? 4 * m_k : ((4 - m_addr[1:0] < m_rem) ? 4 - m_addr[1:0] : m_rem);
      m_be = (m_k > 1) ? 4'h0 : ~(4'((1 << m_n) - 1) << m_addr[1:0]);
      chk("req_addr", m_addr, req_addr_o);
      chk("req_dwords", m_k, req_dwords_o);
      chk("req_cmd", m_cmd, req_cmd_o);
      chk("req_be_n", m_be, req_be_n_o);
      m_rem = m_rem - m_n;
      m_addr = (m_k > 1) ? m_addr + 4 * m_k : {m_addr[31:2], 2'h0} + 32'h4;
    end
  end

  task automatic run_job(input logic [31:0] a, input int cnt, input logic wr, input logic io);
    int t;
    j = {chip_test_five_reg_i[2], dma_mode_reg_i[7:6]};
    m_burst = (j > 5) ? 128 : 2 << j;
    m_eff = 2;
    while (m_eff * 2 <= cache_line_size_i && m_eff < 128) m_eff = m_eff * 2;
    // With cache mode off or an unusable line size, the burst size alone sets the line.
    m_eff = (m_eff < m_burst && cache_mode_enable_i && cache_line_size_i > 8'h01) ? m_eff : m_burst;
    start_addr_i = a;
    byte_count_i = cnt[23:0];
    job_write_i = wr;
    job_io_i = io;
    m_addr = a;
    m_rem = cnt;
    @(posedge clock_i);
    #1;
    chk("eff_line", m_eff, eff_line_o);
    start_i = 1'b1;
    done_seen = 1'b0;
    @(posedge clock_i);
    #1;
    start_i = 1'b0;
    chk("busy", 1, busy_o);
    if (cnt == 0) begin
      @(posedge clock_i);
      #1;
      chk("zero_done", 1, done_o);
    end
    for (t = 0; t < 4000 && (!done_seen || req_valid_o); t++) begin
      @(posedge clock_i);
      #1;
    end
    chk("job_done", 1, done_seen);
    chk("bytes_left", 0, m_rem);
  endtask

  task automatic tgt(input logic [3:0] c, input logic [31:0] a, input logic sel);
    logic h;
    ad_i = a;
    cbe_i = c;
    idsel_i = sel;
    addr_phase_i = 1'b1;
    @(posedge clock_i);
    #1;
    addr_phase_i = 1'b0;
    h = (c inside {4'h2, 4'h3} && a[31:8] == io_base_i) || (c inside {4'ha, 4'hb} && sel && a[10:8] == 3'h0)
        || (c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf} && a[31:8] == mem_base_i);
    chk("tgt_hit", h, tgt_hit_o);
    if (h) begin
      chk("tgt_cmd", (c == 4'hc || c == 4'he) ? 4'h6 : (c == 4'hf) ? 4'h7 : c, tgt_cmd_o);
      chk("tgt_reg", a[7:0], tgt_reg_o);
    end
    @(posedge clock_i);
    #1;
  endtask

  initial begin
    {rstn_i, start_i, job_write_i, job_io_i, addr_phase_i, idsel_i, stall, done_seen} = '0;
    {start_addr_i, byte_count_i, ad_i, cbe_i, err_count, cmp_count, cycles} = '0;
    {dma_mode_reg_i, chip_test_three_reg_i, chip_test_five_reg_i, pci_command_reg_i} = '0;
    cache_line_size_i = 8'h10;
    cache_mode_enable_i = 1'b1;
    io_base_i = 24'h00c3a5;
    mem_base_i = 24'h8e5107;
    seed = 32'h3e1c4cb2;
    repeat (10) @(posedge clock_i);
    #1;
    chk("eff_reset", 2, eff_line_o);
    rstn_i = 1'b1;
    for (i = 0; i < 16; i++) begin
      r = rnd();
      tgt(4'(i), {mem_base_i, r[7:0]}, 1'b1);
      tgt(4'(i), {io_base_i, r[15:8]}, 1'b0);
      tgt(4'(i), {~mem_base_i[23], mem_base_i[22:0], r[7:0]}, 1'b0);
      tgt(4'(i), rnd() & 32'hfffff8ff, r[16]);
    end
    // Line 16 and burst 16, starting one byte into a dword.
    dma_mode_reg_i = 8'hcc;
    chip_test_three_reg_i = 8'h01;
    pci_command_reg_i = 8'h10;
    run_job(32'h0000_0001, 300, 1'b0, 1'b0);
    run_job(32'h0000_0001, 300, 1'b1, 1'b0);
    stall = 1'b1;
    for (i = 0; i < 16; i++) begin
      r = rnd();
      j = 1 + r[31:8] % 7;
      cache_line_size_i = 8'(4 + r[7:0] % 200);
      dma_mode_reg_i = {2'(j), r[13:8]};
      chip_test_five_reg_i = {r[19:15], 1'(j >> 2), r[21:20]};
      chip_test_three_reg_i = r[29:22];
      pci_command_reg_i = {r[17:14], r[3:0]};
      cache_mode_enable_i = r[30] | r[31];
      r = rnd();
      run_job(r & 32'h7fff_ffff, int'(r[29:20]), r[30], r[19:17] == 3'h0);
    end
    run_job(32'h0000_0040, 0, 1'b0, 1'b0);
    close_out();
  end
endmodule

bind pci_cmd_align pci_cmd_align_assertions u_chk (.*);
